// ---- logic/twee_slave.v ----
// Two-wire serial memory slave with its write-data FIFO
`timescale 1ns/1ps
`include "twee_map.vh"

// ----------------------------------------------------------------
// Write-data FIFO
// ----------------------------------------------------------------
module twee_fifo #(
  parameter W = 17,
  parameter D = 16,
  parameter AW = 4
) (
  input wire clk_in,
  input wire rstn_in,
  input wire flush_in,
  input wire in_valid_in,
  input wire [W-1:0] in_data_in,
  output wire in_ready_out,
  output wire out_valid_out,
  output wire [W-1:0] out_data_out,
  input wire out_ready_in
);
  reg [W-1:0] mem_r [0:D-1]; // Storage words
  reg [AW:0] wr_ptr_r; // Write pointer, extra wrap bit
  reg [AW:0] rd_ptr_r; // Read pointer, extra wrap bit
  wire full_w, empty_w; // Occupancy flags
  wire push_w, pop_w; // Accepted transfers

  // Full when pointers differ only in the wrap bit
  assign full_w = (wr_ptr_r[AW] != rd_ptr_r[AW]) &&
                  (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty_w = (wr_ptr_r == rd_ptr_r);
  assign in_ready_out = ~full_w;
  assign out_valid_out = ~empty_w;
  assign out_data_out = mem_r[rd_ptr_r[AW-1:0]];
  assign push_w = in_valid_in & ~full_w;
  assign pop_w = out_ready_in & ~empty_w;

  // Storage write, no reset needed on data
  always @(posedge clk_in) begin
    if (push_w && !flush_in) begin
      mem_r[wr_ptr_r[AW-1:0]] <= in_data_in;
    end
  end

  // Pointer update; flush discards everything held
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else if (flush_in) begin
      wr_ptr_r <= {(AW+1){1'b0}};
      rd_ptr_r <= {(AW+1){1'b0}};
    end else begin
      if (push_w) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop_w) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end
endmodule // twee_fifo

// ----------------------------------------------------------------
// Slave controller
// ----------------------------------------------------------------
// Overview of operation
// (RL1) Sample data on clock rise, change on fall
// (RL2) Two straps set address, third ignored
// (RL3) Protect input high blocks all programming
// (RL4) Array is 512 bytes, 9-bit address
// (RL5) Data fall with clock high starts
// (RL6) Data rise with clock high stops, standby
// (RL7) Eight-bit words, ack low on ninth clock
// (RL8) Address word top nibble is one-zero-one-zero
// (RL9) Next bits match straps, then page bit
// (RL10) Eighth bit one reads, zero writes
// (RL11) Match acks; mismatch goes standby until start
// (RL12) Byte write: word address, data, stop
// (RL13) Stop after write starts timed programming, deaf
// (RL14) Page write takes up to sixteen bytes
// (RL15) Writes bump only low four address bits
// (RL16) No address ack while programming; master polls
// (RL17) Counter keeps last address plus one
// (RL18) Reads wrap from last byte to first
// (RL19) Current read sends byte at counter
// (RL20) Dummy write, repeated start, then read
// (RL21) Master ack continues read, nack ends
// (RL22) Programming time counted from stop condition
// (RL23) Protected writes acked but array untouched
module twee_slave #(
  parameter [31:0] WR_CYCLES = `TWEE_WR_CYCLES, // Programming time
  parameter FIFO_DEPTH = `TWEE_PAGE_DEPTH,
  parameter FIFO_AW = `TWEE_PAGE_BITS
) (
  input wire clk_in,
  input wire rstn_in,
  input wire scl_in,
  input wire sda_in,
  output reg sda_out,
  output reg sda_oe_n_out,
  input wire strap_addr_bit0_unused_in,
  input wire strap_addr_bit1_in,
  input wire strap_addr_bit2_in,
  input wire wp_in,
  output reg busy_out
);
  // ----------------------------------------------------------------
  // State codes
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0; // Standby, waits for start
  localparam [2:0] ST_RX = 3'h1; // Shifting in a byte
  localparam [2:0] ST_ACKW = 3'h2; // Byte in, waiting to drive ack
  localparam [2:0] ST_ACK = 3'h3; // Ack driven during ninth clock
  localparam [2:0] ST_TX = 3'h4; // Shifting out a byte
  localparam [2:0] ST_MACK = 3'h5; // Master ack slot
  localparam [2:0] ST_PROG = 3'h6; // Timed programming, deaf
  localparam [1:0] PH_DEV = 2'h0, PH_WA = 2'h1, PH_WD = 2'h2; // Byte phases
  localparam FW = `TWEE_ADDR_W + `TWEE_DATA_W; // FIFO word width

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Page-local increment: upper bits stay, low four wrap
  function [`TWEE_ADDR_W-1:0] page_inc;
    input [`TWEE_ADDR_W-1:0] a;
    begin
      page_inc = {a[`TWEE_ADDR_W-1:`TWEE_PAGE_BITS],
                  a[`TWEE_PAGE_BITS-1:0] + 1'b1};
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage and state
  // ----------------------------------------------------------------
  reg [`TWEE_DATA_W-1:0] mem_r [0:`TWEE_MEM_WORDS-1]; // Array
  reg scl_m_r, scl_s_r, scl_d_r; // Clock synchroniser and history
  reg sda_m_r, sda_s_r, sda_d_r; // Data synchroniser and history
  reg a1_m_r, a1_s_r, a2_m_r, a2_s_r; // Strap synchronisers
  reg wp_m_r, wp_s_r; // Protect synchroniser
  reg [2:0] st_r; // Main state
  reg [1:0] ph_r; // Which byte of a command
  reg [2:0] cnt_r; // Bit counter
  reg [`TWEE_DATA_W-1:0] sh_r; // Receive shift register
  reg [`TWEE_DATA_W-1:0] tx_r; // Transmit shift register
  reg [`TWEE_ADDR_W-1:0] addr_r; // Address counter, kept forever
  reg page_r; // Page bit from the device word
  reg rd_r, ack_r, mack_r; // Read command, our ack, master ack
  reg wr_pend_r; // Data bytes queued for programming
  reg [31:0] tmr_r; // Programming timer
  reg push_r, flush_r; // Queue push and discard strobes
  reg [FW-1:0] push_dat_r; // Address and data pushed

  wire scl_rise_w, scl_fall_w; // Synced clock edges
  wire start_w, stop_w; // Bus conditions
  wire [`TWEE_DATA_W-1:0] rx_byte_w; // Byte including current bit
  wire dev_match_w, drain_w; // Address hit, queue drain
  wire fifo_ready_w, fifo_valid_w; // Queue handshake
  wire [FW-1:0] fifo_dat_w; // Queued address and data

  // ----------------------------------------------------------------
  // Input synchronisers, two flops before any logic
  // ----------------------------------------------------------------
  // Bus pins and straps come from outside this clock domain
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      // Bus lines idle high, so no false edge follows reset
      {scl_m_r, scl_s_r, scl_d_r} <= 3'h7;
      {sda_m_r, sda_s_r, sda_d_r} <= 3'h7;
      {a1_m_r, a1_s_r, a2_m_r, a2_s_r} <= 4'h0;
      {wp_m_r, wp_s_r} <= 2'h0;
    end else begin
      scl_m_r <= scl_in;
      scl_s_r <= scl_m_r;
      scl_d_r <= scl_s_r;
      sda_m_r <= sda_in;
      sda_s_r <= sda_m_r;
      sda_d_r <= sda_s_r;
      a1_m_r <= strap_addr_bit1_in;
      a1_s_r <= a1_m_r;
      a2_m_r <= strap_addr_bit2_in;
      a2_s_r <= a2_m_r;
      wp_m_r <= wp_in;
      wp_s_r <= wp_m_r;
    end
  end

  // ----------------------------------------------------------------
  // Edge and condition detection
  // ----------------------------------------------------------------
  assign scl_rise_w = scl_s_r & ~scl_d_r;
  assign scl_fall_w = ~scl_s_r & scl_d_r;
  // Data edges only count while the clock stays high
  assign start_w = scl_s_r & scl_d_r & sda_d_r & ~sda_s_r; // RL5
  assign stop_w = scl_s_r & scl_d_r & ~sda_d_r & sda_s_r; // RL6
  assign rx_byte_w = {sh_r[`TWEE_DATA_W-2:0], sda_s_r}; // RL7
  // Fixed nibble, then the two straps; bit0 strap never looked at
  assign dev_match_w =
    (rx_byte_w[`TWEE_DEV_CODE_HI:`TWEE_DEV_CODE_LO] ==
     `TWEE_DEV_CODE) && // RL8
    (rx_byte_w[`TWEE_DEV_STRAP2] == a2_s_r) &&
    (rx_byte_w[`TWEE_DEV_STRAP1] == a1_s_r); // RL2 RL9
  // Queue drains only during programming, so it really fills
  assign drain_w = (st_r == ST_PROG);

  // ----------------------------------------------------------------
  // Page buffer
  // ----------------------------------------------------------------
  twee_fifo #(
    .W(FW),
    .D(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .flush_in(flush_r),
    .in_valid_in(push_r),
    .in_data_in(push_dat_r),
    .in_ready_out(fifo_ready_w),
    .out_valid_out(fifo_valid_w),
    .out_data_out(fifo_dat_w),
    .out_ready_in(drain_w)
  );

  // ----------------------------------------------------------------
  // Array write, one queued byte per clock while programming
  // ----------------------------------------------------------------
  always @(posedge clk_in) begin
    if (drain_w && fifo_valid_w) begin
      mem_r[fifo_dat_w[FW-1:`TWEE_DATA_W]] <=
        fifo_dat_w[`TWEE_DATA_W-1:0]; // RL4 RL13
    end
  end

  // ----------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------
  always @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_r <= ST_IDLE;
      ph_r <= PH_DEV;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      addr_r <= 9'h000;
      page_r <= 1'b0;
      rd_r <= 1'b0;
      ack_r <= 1'b0;
      mack_r <= 1'b0;
      wr_pend_r <= 1'b0;
      tmr_r <= 32'h0000_0000;
      push_r <= 1'b0;
      push_dat_r <= {FW{1'b0}};
      flush_r <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_n_out <= 1'b1;
      busy_out <= 1'b0;
    end else begin
      // Strobes last one clock
      push_r <= 1'b0;
      flush_r <= 1'b0;
      sda_out <= 1'b0; // Open drain: only ever pulls low
      if (st_r == ST_PROG) begin
        // All inputs ignored until the timer runs out
        if (tmr_r == WR_CYCLES - 32'h1) begin // RL22
          st_r <= ST_IDLE;
          busy_out <= 1'b0;
        end else begin
          tmr_r <= tmr_r + 32'h1; // RL13 RL16
        end
      end else if (start_w) begin
        // Start (or repeated start) from any state except timed programming
        st_r <= ST_RX; // RL5
        ph_r <= PH_DEV;
        cnt_r <= 3'h0;
        sda_oe_n_out <= 1'b1;
        // An unterminated write is thrown away
        wr_pend_r <= 1'b0;
        flush_r <= 1'b1;
      end else if (stop_w) begin
        sda_oe_n_out <= 1'b1;
        if (wr_pend_r && !wp_s_r) begin
          st_r <= ST_PROG; // RL13 RL22
          tmr_r <= 32'h0000_0000;
          busy_out <= 1'b1;
        end else begin
          st_r <= ST_IDLE; // RL6 RL3 RL23
          flush_r <= 1'b1;
        end
        wr_pend_r <= 1'b0;
      end else begin
        case (st_r)
          ST_RX: begin
            // Sample on the rising clock edge
            if (scl_rise_w) begin // RL1
              sh_r <= rx_byte_w;
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r == `TWEE_LAST_BIT) begin
                st_r <= ST_ACKW;
                case (ph_r)
                  PH_DEV: begin
                    ack_r <= dev_match_w; // RL11
                    rd_r <= rx_byte_w[`TWEE_DEV_RW]; // RL10
                    page_r <= rx_byte_w[`TWEE_DEV_PAGE]; // RL9
                  end
                  PH_WA: begin
                    ack_r <= 1'b1; // RL12
                    addr_r <= {page_r, rx_byte_w}; // RL20
                  end
                  PH_WD: begin
                    // Full page queue refuses the byte with a nack
                    ack_r <= fifo_ready_w; // RL14
                    if (fifo_ready_w) begin
                      // Protected bytes are acked but never queued
                      if (!wp_s_r) begin // RL3 RL23
                        push_r <= 1'b1;
                        push_dat_r <= {addr_r, rx_byte_w};
                        wr_pend_r <= 1'b1;
                      end
                      addr_r <= page_inc(addr_r); // RL15 RL17
                    end
                  end
                  default: begin
                    ack_r <= 1'b0;
                  end
                endcase
              end
            end
          end
          ST_ACKW: begin
            // Drive ack on the falling edge before the ninth clock
            if (scl_fall_w) begin
              if (ack_r) begin
                sda_oe_n_out <= 1'b0; // RL7
                st_r <= ST_ACK;
              end else begin
                st_r <= ST_IDLE; // RL11
              end
            end
          end
          ST_ACK: begin
            // Ninth clock ends: release or start sending
            if (scl_fall_w) begin
              cnt_r <= 3'h0;
              if (ph_r == PH_DEV && rd_r) begin
                tx_r <= mem_r[addr_r]; // RL19
                sda_oe_n_out <= mem_r[addr_r][`TWEE_MSB]; // RL1
                addr_r <= addr_r + 9'h001; // RL17 RL18
                st_r <= ST_TX;
              end else begin
                sda_oe_n_out <= 1'b1;
                st_r <= ST_RX;
                if (ph_r == PH_DEV) begin
                  ph_r <= PH_WA;
                end else begin
                  ph_r <= PH_WD;
                end
              end
            end
          end
          ST_TX: begin
            // Change outgoing data only on the falling edge
            if (scl_fall_w) begin // RL1
              if (cnt_r == `TWEE_LAST_BIT) begin
                sda_oe_n_out <= 1'b1;
                st_r <= ST_MACK;
              end else begin
                cnt_r <= cnt_r + 3'h1;
                sda_oe_n_out <= tx_r[`TWEE_MSB-1];
                tx_r <= {tx_r[`TWEE_DATA_W-2:0], 1'b0};
              end
            end
          end
          ST_MACK: begin
            if (scl_rise_w) begin
              mack_r <= ~sda_s_r; // RL21
            end else if (scl_fall_w) begin
              cnt_r <= 3'h0;
              if (mack_r) begin
                // Master wants more: next byte, full wrap
                tx_r <= mem_r[addr_r]; // RL21
                sda_oe_n_out <= mem_r[addr_r][`TWEE_MSB];
                addr_r <= addr_r + 9'h001; // RL18
                st_r <= ST_TX;
              end else begin
                st_r <= ST_IDLE; // RL21 RL19
              end
            end
          end
          default: begin
            // Standby or stray code: line released, start watched
            st_r <= ST_IDLE;
            sda_oe_n_out <= 1'b1;
          end
        endcase
      end
    end
  end
endmodule // twee_slave

// ---- logic/twee_map.vh ----
// Constants of the two-wire serial memory slave
`ifndef TWEE_MAP_VH
`define TWEE_MAP_VH

// ----------------------------------------------------------------
// Array geometry
// ----------------------------------------------------------------
`define TWEE_ADDR_W 9
`define TWEE_DATA_W 8
`define TWEE_MEM_WORDS 512
`define TWEE_PAGE_BITS 4
`define TWEE_PAGE_DEPTH 16

// ----------------------------------------------------------------
// Device address word layout
// ----------------------------------------------------------------
`define TWEE_DEV_CODE 4'ha
`define TWEE_DEV_CODE_HI 7
`define TWEE_DEV_CODE_LO 4
`define TWEE_DEV_STRAP2 3
`define TWEE_DEV_STRAP1 2
`define TWEE_DEV_PAGE 1
`define TWEE_DEV_RW 0

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define TWEE_LAST_BIT 3'h7
`define TWEE_MSB 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define TWEE_CLK_MHZ 50
`define TWEE_WR_TIME_US 5000
`define TWEE_WR_CYCLES (`TWEE_WR_TIME_US * `TWEE_CLK_MHZ)

`endif

// ---- verification/twee_checker.sv ----
// Pin-level assertions for the serial memory slave
`timescale 1ns/1ps
module twee_checker #(
  parameter [31:0] WR_CYCLES = 32'hc8
) (
  input wire clk_in,
  input wire rstn_in,
  input wire scl_in,
  input wire sda_in,
  input wire sda_oe_n_out,
  input wire wp_in,
  input wire busy_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!rstn_in);
  // ----------------------------------------------------------------
  // Helper counters
  // ----------------------------------------------------------------
  logic [31:0] busy_cnt_r; // Cycles spent programming
  logic [7:0] since_stop_r; // Cycles since a stop on the pins
  logic sda_q_r; // Data level one cycle back
  // Saturating count, so a rise long after a stop still fails
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt_r <= 32'h0;
      since_stop_r <= 8'hff;
      sda_q_r <= 1'h1;
    end else begin
      sda_q_r <= sda_in;
      busy_cnt_r <= busy_out ? busy_cnt_r + 32'h1 : 32'h0;
      if (scl_in && sda_in && !sda_q_r) begin // Stop seen
        since_stop_r <= 8'h0;
      end else if (since_stop_r != 8'hff) begin
        since_stop_r <= since_stop_r + 8'h1;
      end
    end
  end
  // ----------------------------------------------------------------
  // Sequences and assertions
  // ----------------------------------------------------------------
  sequence scl_high3;
    scl_in [*3];
  endsequence
  sequence stop_cond;
    scl_in && $rose(sda_in);
  endsequence
  drive_on_low_a: assert property (
    $fell(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("data pulled low outside clock low phase");
  release_on_low_a: assert property (
    $rose(sda_oe_n_out) |-> !scl_in && !$past(scl_in, 2))
    else $error("data released outside clock low phase");
  stable_high_a: assert property (
    scl_high3 |-> $stable(sda_oe_n_out))
    else $error("device data moved while clock high");
  busy_silent_a: assert property (
    busy_out |-> sda_oe_n_out)
    else $error("device answered while programming");
  busy_length_a: assert property (
    $fell(busy_out) |-> busy_cnt_r == WR_CYCLES)
    else $error("programming time wrong");
  busy_after_stop_a: assert property (
    $rose(busy_out) |-> since_stop_r <= 8'h6)
    else $error("programming started without a stop");
  protect_block_a: assert property (
    $rose(busy_out) |-> !wp_in && !$past(wp_in, 6))
    else $error("programming started while protected");
  reset_idle_a: assert property (
    $rose(rstn_in) |-> sda_oe_n_out && !busy_out)
    else $error("outputs not idle after reset");
  cover property (stop_cond ##[1:8] $rose(busy_out));
endmodule // twee_checker

bind twee_slave twee_checker #(.WR_CYCLES(WR_CYCLES)) u_chk (
  .clk_in(clk_in),
  .rstn_in(rstn_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_oe_n_out(sda_oe_n_out),
  .wp_in(wp_in),
  .busy_out(busy_out)
);

// ---- verification/twee_master.sv ----
// Bus master model that clocks the serial memory slave
`timescale 1ns/1ps
module twee_master (
  input wire clk_in,
  input wire sda_in,
  output logic scl_out,
  output logic sda_low_out
);
  // Idle bus: clock parked high, data left to the pull-up
  initial begin
    scl_out = 1'h1;
    sda_low_out = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // One bit: set in low phase, sample mid high phase
  task automatic bit_cyc(input logic b, input int lw, output logic s);
    tick(1);
    sda_low_out = !b;
    tick(lw);
    scl_out = 1'h1;
    tick(2);
    s = sda_in;
    tick(2);
    scl_out = 1'h0;
  endtask
  // Long low phase first, so a late ack release settles
  task automatic cond_start;
    if (!scl_out) begin
      tick(1);
      sda_low_out = 1'h0;
      tick(6);
      scl_out = 1'h1;
    end
    tick(4);
    sda_low_out = 1'h1;
    tick(4);
    scl_out = 1'h0;
  endtask
  task automatic cond_stop;
    tick(1);
    sda_low_out = 1'h1;
    tick(5);
    scl_out = 1'h1;
    tick(4);
    sda_low_out = 1'h0;
    tick(8);
  endtask
  // Byte out, most significant bit first, ack sampled
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(d[i], (i == 7) ? 6 : 3, s);
    bit_cyc(1'h1, 3, s);
    ack = !s;
  endtask
  // Master ack keeps a read going, release ends it
  task automatic rd_byte(input logic mack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(1'h1, 3, d[i]);
    bit_cyc(!mack, 3, s);
  endtask
endmodule // twee_master

// ---- verification/test_two_wire_eeprom_slave.sv ----
// Self-checking bench for the serial memory slave
`timescale 1ns/1ps
`include "twee_map.vh"
`define CHK(a, e) \
  begin \
    checks++; \
    if ((a) !== (e)) begin \
      err_total++; \
      $display("Error at %0t: got %h expected %h", $time, a, e); \
    end \
  end
module test_two_wire_eeprom_slave;
  localparam logic [31:0] WR = 32'hc8; // Short programming time
  // Device word: straps two high, one low, page bit clear
  localparam logic [7:0] DW = {`TWEE_DEV_CODE, 4'h8};
  logic clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic wp_in = 1'h0;
  logic s0 = 1'h0;
  logic s1 = 1'h0;
  logic s2 = 1'h1;
  int err_total = 0;
  int checks = 0;
  int cyc = 0;
  wire scl;
  wire sda_low;
  wire sda_out;
  wire sda_oe_n_out;
  wire busy_out;
  wire sda = (sda_oe_n_out | sda_out) & !sda_low; // Pulled-up wire
  twee_slave #(.WR_CYCLES(WR)) dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
    .strap_addr_bit0_unused_in(s0), .strap_addr_bit1_in(s1),
    .strap_addr_bit2_in(s2), .wp_in(wp_in), .busy_out(busy_out));
  twee_master bus_master (.clk_in(clk_in), .sda_in(sda), .scl_out(scl),
    .sda_low_out(sda_low));
  // ----------------------------------------------------------------
  // Clock, watchdog, verdict
  // ----------------------------------------------------------------
  initial begin
    forever #10 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 40000) begin // Hang guard
      err_total++;
      results();
    end
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus helpers
  // ----------------------------------------------------------------
  task automatic put(input logic [7:0] b, input logic e);
    logic a;
    bus_master.wr_byte(b, a);
    `CHK(a, e)
  endtask
  task automatic set_addr(input logic [8:0] a);
    bus_master.cond_start();
    put(DW | {6'h0, a[8], 1'h0}, 1'h1);
    put(a[7:0], 1'h1);
  endtask
  // Write a run of bytes, optionally one too many
  task automatic wr(input logic [8:0] a, input logic [7:0] q[$],
                    input logic prog, input logic over);
    set_addr(a);
    foreach (q[i])
      put(q[i], 1'h1);
    if (over)
      put(8'hee, 1'h0);
    bus_master.cond_stop();
    `CHK(busy_out, prog)
  endtask
  task automatic idle;
    for (int i = 0; i < WR + 20 && busy_out !== 1'h0; i++)
      @(negedge clk_in);
    `CHK(busy_out, 1'h0)
  endtask
  // Dummy write, repeated start, then sequential bytes
  task automatic rd(input logic [8:0] a, input logic [7:0] q[$]);
    logic [7:0] d;
    set_addr(a);
    bus_master.cond_start();
    put(DW | 8'h1, 1'h1);
    foreach (q[i]) begin
      bus_master.rd_byte(i < q.size() - 1, d);
      `CHK(d, q[i])
    end
    bus_master.cond_stop();
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_byte;
    wr(9'h135, {8'ha5}, 1'h1, 1'h0);
    bus_master.cond_start();
    put(DW, 1'h0);
    bus_master.cond_stop();
    idle();
    rd(9'h135, {8'ha5});
  endtask
  task automatic t_page;
    logic [7:0] q[$];
    logic [7:0] e[$];
    logic [7:0] d;
    for (int i = 0; i < 16; i++)
      q.push_back(8'h40 + 8'(i));
    for (int j = 0; j < 16; j++)
      e.push_back(8'h40 + 8'((j + 4) % 16));
    wr(9'h07c, q, 1'h1, 1'h1);
    idle();
    bus_master.cond_start();
    put(DW | 8'h1, 1'h1);
    bus_master.rd_byte(1'h0, d);
    `CHK(d, 8'h40)
    bus_master.cond_stop();
    rd(9'h070, e);
  endtask
  task automatic t_wrap;
    wr(9'h1ff, {8'h3c}, 1'h1, 1'h0);
    idle();
    wr(9'h000, {8'hc3}, 1'h1, 1'h0);
    idle();
    rd(9'h1ff, {8'h3c, 8'hc3});
  endtask
  // Wrong straps and wrong code stay silent until the next start
  task automatic t_addr;
    logic [7:0] bad [4] = '{8'ha4, 8'ha0, 8'hac, 8'hb8};
    foreach (bad[i]) begin
      bus_master.cond_start();
      put(bad[i], 1'h0);
      put(8'h00, 1'h0);
      bus_master.cond_stop();
    end
    s0 = 1'h1;
    rd(9'h135, {8'ha5});
  endtask
  task automatic t_wp;
    wp_in = 1'h1;
    wr(9'h135, {8'h11}, 1'h0, 1'h0);
    rd(9'h135, {8'ha5});
    wp_in = 1'h0;
  endtask
  initial begin
    repeat (12) @(negedge clk_in);
    rstn_in = 1'h1;
    repeat (4) @(negedge clk_in);
    t_byte();
    t_page();
    t_wrap();
    t_addr();
    t_wp();
    results();
  end
endmodule // test_two_wire_eeprom_slave
